// File: hw/bmu_pkg.sv
// Shared constants and the operation encoding of the bit manipulation unit
package bmu_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int POS_W  = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_DATA  = 16'h0000;
    localparam logic [POS_W-1:0]  RST_INDEX = 4'h0;
    localparam logic              RST_FLAG  = 1'h0;

    // ------------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        bit_and_carry,
        bit_or_carry,
        bit_xor_carry,
        bit_and_inverted_carry,
        bit_or_inverted_carry,
        bit_xor_inverted_carry,
        bit_force_one,
        bit_force_zero,
        bit_complement,
        bit_probe,
        bit_probe_inverted,
        bit_probe_then_zero,
        bit_probe_then_one,
        bit_index_prefix,
        cond_store_carry_set,
        cond_store_carry_clear,
        cond_store_equal,
        cond_store_not_equal,
        cond_store_unsigned_higher,
        cond_store_unsigned_lower_same,
        cond_store_positive,
        cond_store_negative,
        cond_store_signed_ge,
        cond_store_signed_lt,
        cond_store_signed_le,
        cond_store_signed_gt,
        cond_store_overflow,
        cond_store_no_overflow
    } bmu_op_t;

endpackage : bmu_pkg

// File: hw/bmu_core.sv
// Bit manipulation datapath: bit logic into carry, bit writes, tests, index prefix
`timescale 1ns/1ps

module bmu_core (
    // Clock and reset
    input  wire logic                        mclk_i,
    input  wire logic                        arst_n_i,
    // Instruction side
    input  wire logic                        op_valid_i,
    input  wire bmu_pkg::bmu_op_t            op_i,
    input  wire logic [bmu_pkg::POS_W-1:0]   bit_sel_i,
    input  wire logic [bmu_pkg::DATA_W-1:0]  operand_i,
    // Flag register side
    input  wire logic                        flag_c_i,
    input  wire logic                        flag_z_i,
    input  wire logic                        flag_s_i,
    input  wire logic                        flag_o_i,
    // Results
    output logic                             res_valid_o,
    output logic                             res_wr_o,
    output logic [bmu_pkg::DATA_W-1:0]       res_data_o,
    output logic                             flag_c_o,
    output logic                             flag_z_o,
    output logic                             flag_c_wr_o,
    output logic                             flag_z_wr_o,
    output logic                             idx_pend_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [bmu_pkg::POS_W-1:0]  idx;
    logic [bmu_pkg::POS_W-1:0]  bit_pos;
    logic                       src_bit;
    logic                       sxo;
    logic                       cond_bit;
    logic                       is_cond;
    logic [bmu_pkg::DATA_W-1:0] next_data;
    logic                       next_wr;
    logic                       next_c;
    logic                       next_z;
    logic                       next_c_wr;
    logic                       next_z_wr;

    // ------------------------------------------------------------------
    // Bit addressing
    // ------------------------------------------------------------------
    // A pending index overrides the bit number of the instruction
    assign bit_pos = idx_pend_o ? idx : bit_sel_i;
    assign src_bit = operand_i[bit_pos];
    assign sxo     = flag_s_i ^ flag_o_i;

    // ------------------------------------------------------------------
    // Condition evaluation for conditional stores
    // ------------------------------------------------------------------
    always_comb begin
        cond_bit = 1'b0;
        is_cond  = 1'b1;
        case (op_i)
            bmu_pkg::cond_store_carry_set: begin
                cond_bit = flag_c_i;
            end
            bmu_pkg::cond_store_carry_clear: begin
                cond_bit = ~flag_c_i;
            end
            bmu_pkg::cond_store_equal: begin
                cond_bit = flag_z_i;
            end
            bmu_pkg::cond_store_not_equal: begin
                cond_bit = ~flag_z_i;
            end
            bmu_pkg::cond_store_unsigned_higher: begin
                cond_bit = flag_c_i & ~flag_z_i;
            end
            bmu_pkg::cond_store_unsigned_lower_same: begin
                cond_bit = ~(flag_c_i & ~flag_z_i);
            end
            bmu_pkg::cond_store_positive: begin
                cond_bit = ~flag_s_i;
            end
            bmu_pkg::cond_store_negative: begin
                cond_bit = flag_s_i;
            end
            bmu_pkg::cond_store_signed_ge: begin
                cond_bit = ~sxo;
            end
            bmu_pkg::cond_store_signed_lt: begin
                cond_bit = sxo;
            end
            bmu_pkg::cond_store_signed_le: begin
                cond_bit = sxo | flag_z_i;
            end
            bmu_pkg::cond_store_signed_gt: begin
                cond_bit = ~(sxo | flag_z_i);
            end
            bmu_pkg::cond_store_overflow: begin
                cond_bit = flag_o_i;
            end
            bmu_pkg::cond_store_no_overflow: begin
                cond_bit = ~flag_o_i;
            end
            default: begin
                is_cond = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Result computation
    // ------------------------------------------------------------------
    // Defaults pass operand and flags through untouched
    always_comb begin
        next_data = operand_i;
        next_wr   = 1'b0;
        next_c    = flag_c_i;
        next_z    = flag_z_i;
        next_c_wr = 1'b0;
        next_z_wr = 1'b0;
        case (op_i)
            bmu_pkg::bit_and_carry: begin
                next_c    = src_bit & flag_c_i;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_or_carry: begin
                next_c    = src_bit | flag_c_i;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_xor_carry: begin
                next_c    = src_bit ^ flag_c_i;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_and_inverted_carry: begin
                next_c    = ~src_bit & flag_c_i;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_or_inverted_carry: begin
                next_c    = ~src_bit | flag_c_i;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_xor_inverted_carry: begin
                next_c    = ~src_bit ^ flag_c_i;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_force_one: begin
                next_data[bit_pos] = 1'b1;
                next_wr            = 1'b1;
            end
            bmu_pkg::bit_force_zero: begin
                next_data[bit_pos] = 1'b0;
                next_wr            = 1'b1;
            end
            bmu_pkg::bit_complement: begin
                next_data[bit_pos] = ~src_bit;
                next_wr            = 1'b1;
            end
            bmu_pkg::bit_probe: begin
                next_z    = src_bit;
                next_c    = src_bit;
                next_z_wr = 1'b1;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_probe_inverted: begin
                next_z    = ~src_bit;
                next_c    = ~src_bit;
                next_z_wr = 1'b1;
                next_c_wr = 1'b1;
            end
            bmu_pkg::bit_probe_then_zero: begin
                next_z             = src_bit;
                next_c             = src_bit;
                next_z_wr          = 1'b1;
                next_c_wr          = 1'b1;
                next_data[bit_pos] = 1'b0;
                next_wr            = 1'b1;
            end
            bmu_pkg::bit_probe_then_one: begin
                next_z             = src_bit;
                next_c             = src_bit;
                next_z_wr          = 1'b1;
                next_c_wr          = 1'b1;
                next_data[bit_pos] = 1'b1;
                next_wr            = 1'b1;
            end
            default: begin
                if (is_cond) begin
                    next_data[bit_pos] = cond_bit;
                    next_wr            = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Index prefix register
    // ------------------------------------------------------------------
    // Any following bit operation consumes the index
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx        <= bmu_pkg::RST_INDEX;
            idx_pend_o <= bmu_pkg::RST_FLAG;
        end else if (op_valid_i) begin
            if (op_i == bmu_pkg::bit_index_prefix) begin
                idx        <= operand_i[bmu_pkg::POS_W-1:0];
                idx_pend_o <= 1'b1;
            end else begin
                idx_pend_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_valid_o <= bmu_pkg::RST_FLAG;
            res_wr_o    <= bmu_pkg::RST_FLAG;
            flag_c_wr_o <= bmu_pkg::RST_FLAG;
            flag_z_wr_o <= bmu_pkg::RST_FLAG;
        end else begin
            res_valid_o <= op_valid_i;
            res_wr_o    <= op_valid_i & next_wr;
            flag_c_wr_o <= op_valid_i & next_c_wr;
            flag_z_wr_o <= op_valid_i & next_z_wr;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_data_o <= bmu_pkg::RST_DATA;
            flag_c_o   <= bmu_pkg::RST_FLAG;
            flag_z_o   <= bmu_pkg::RST_FLAG;
        end else if (op_valid_i) begin
            res_data_o <= next_data;
            flag_c_o   <= next_c;
            flag_z_o   <= next_z;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_and_carry: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_and_carry
        |=> flag_c_wr_o && flag_c_o == ($past(src_bit) & $past(flag_c_i)) && !res_wr_o
    ) else $error("carry AND result wrong");

    chk_inv_xor: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_xor_inverted_carry
        |=> flag_c_wr_o && flag_c_o == ($past(src_bit) ~^ $past(flag_c_i))
    ) else $error("inverted carry XOR result wrong");

    chk_complement_bit: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_complement
        |=> res_wr_o && (res_data_o ^ $past(operand_i)) == (16'h0001 << $past(bit_pos))
    ) else $error("complement did not flip exactly the addressed bit");

    chk_force_one: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_force_one
        |=> res_wr_o && res_data_o[$past(bit_pos)] && !flag_c_wr_o && !flag_z_wr_o
    ) else $error("force-one did not set the addressed bit");

    chk_probe_flags: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_probe
        |=> flag_z_o == $past(src_bit) && flag_c_o == flag_z_o && !res_wr_o
    ) else $error("probe flags wrong or operand written");

    chk_probe_inverted: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_probe_inverted
        |=> flag_z_wr_o && flag_z_o != $past(src_bit) && flag_c_o == flag_z_o
    ) else $error("inverted probe flags wrong");

    chk_probe_clear: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_probe_then_zero
        |=> flag_c_o == $past(src_bit) && res_wr_o && !res_data_o[$past(bit_pos)]
    ) else $error("probe-then-zero wrong");

    chk_index_use: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::bit_index_prefix ##1
        op_valid_i && op_i != bmu_pkg::bit_index_prefix
        |-> bit_pos == $past(operand_i[bmu_pkg::POS_W-1:0]) ##1 !idx_pend_o
    ) else $error("index prefix not applied to next operation");

    chk_carry_store: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::cond_store_carry_set
        |=> res_wr_o && res_data_o[$past(bit_pos)] == $past(flag_c_i)
    ) else $error("carry-set store wrong");

    chk_carry_clear: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::cond_store_carry_clear
        |=> res_wr_o && res_data_o[$past(bit_pos)] == !$past(flag_c_i)
    ) else $error("carry-clear store wrong");

    chk_equal_store: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::cond_store_equal
        |=> res_wr_o && res_data_o[$past(bit_pos)] == $past(flag_z_i)
    ) else $error("equal store wrong");

    chk_negative_store: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::cond_store_negative
        |=> res_wr_o && res_data_o[$past(bit_pos)] == $past(flag_s_i)
    ) else $error("negative store wrong");

    chk_no_overflow: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::cond_store_no_overflow
        |=> res_wr_o && res_data_o[$past(bit_pos)] == !$past(flag_o_i)
    ) else $error("no-overflow store wrong");

    chk_higher_store: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::cond_store_unsigned_higher
        |=> res_data_o[$past(bit_pos)] == ($past(flag_c_i) && !$past(flag_z_i))
    ) else $error("unsigned higher store wrong");

    chk_signed_le: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && op_i == bmu_pkg::cond_store_signed_le
        |=> res_data_o[$past(bit_pos)] == ($past(sxo) | $past(flag_z_i))
    ) else $error("signed le store wrong");

    chk_other_bits: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i |=> $onehot0(res_data_o ^ $past(operand_i)) && res_valid_o
    ) else $error("more than one operand bit changed");

    chk_flags_kept: assert property (
        @(posedge mclk_i) disable iff (!arst_n_i)
        op_valid_i && is_cond |=> !flag_c_wr_o && !flag_z_wr_o
    ) else $error("conditional store touched a flag");

endmodule : bmu_core

// File: tb/bmu_core_bench.sv
// Self-checking testbench for the bit manipulation datapath
`timescale 1ns/1ps

module bmu_core_bench;

    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic                           mclk_i;
    logic                           arst_n_i;
    logic                           op_valid_i;
    bmu_pkg::bmu_op_t               op_i;
    logic [bmu_pkg::POS_W-1:0]      bit_sel_i;
    logic [bmu_pkg::DATA_W-1:0]     operand_i;
    logic                           flag_c_i;
    logic                           flag_z_i;
    logic                           flag_s_i;
    logic                           flag_o_i;
    logic                           res_valid_o;
    logic                           res_wr_o;
    logic [bmu_pkg::DATA_W-1:0]     res_data_o;
    logic                           flag_c_o;
    logic                           flag_z_o;
    logic                           flag_c_wr_o;
    logic                           flag_z_wr_o;
    logic                           idx_pend_o;
    int                             mismatches;
    int                             cmp_count;

    bmu_core uut (
        .mclk_i      (mclk_i),
        .arst_n_i    (arst_n_i),
        .op_valid_i  (op_valid_i),
        .op_i        (op_i),
        .bit_sel_i   (bit_sel_i),
        .operand_i   (operand_i),
        .flag_c_i    (flag_c_i),
        .flag_z_i    (flag_z_i),
        .flag_s_i    (flag_s_i),
        .flag_o_i    (flag_o_i),
        .res_valid_o (res_valid_o),
        .res_wr_o    (res_wr_o),
        .res_data_o  (res_data_o),
        .flag_c_o    (flag_c_o),
        .flag_z_o    (flag_z_o),
        .flag_c_wr_o (flag_c_wr_o),
        .flag_z_wr_o (flag_z_wr_o),
        .idx_pend_o  (idx_pend_o)
    );

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        mclk_i = 1'h0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Roughly 300 operations at two cycles each; allow ample margin
    initial begin
        repeat (5000) @(posedge mclk_i);
        $display("BAD watchdog expected completion seen hang");
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk

    // Flags packed as {c, z, s, o}; outputs are judged just after the taking edge
    task automatic drive(input bmu_pkg::bmu_op_t op, input logic [3:0] sel,
                         input logic [15:0] val, input logic [3:0] fl);
        @(posedge mclk_i);
        op_valid_i <= 1'h1;
        op_i       <= op;
        bit_sel_i  <= sel;
        operand_i  <= val;
        {flag_c_i, flag_z_i, flag_s_i, flag_o_i} <= fl;
        @(posedge mclk_i);
        op_valid_i <= 1'h0;
        operand_i  <= ~val;
        #1;
    endtask : drive

    task automatic expect_out(input logic wr, input logic [15:0] data, input logic cwr,
                              input logic c, input logic zwr, input logic z);
        chk("res_valid_o", 16'h0001, {15'h0, res_valid_o});
        chk("res_wr_o", {15'h0, wr}, {15'h0, res_wr_o});
        chk("flag_c_wr_o", {15'h0, cwr}, {15'h0, flag_c_wr_o});
        chk("flag_z_wr_o", {15'h0, zwr}, {15'h0, flag_z_wr_o});
        if (wr) chk("res_data_o", data, res_data_o);
        if (cwr) chk("flag_c_o", {15'h0, c}, {15'h0, flag_c_o});
        if (zwr) chk("flag_z_o", {15'h0, z}, {15'h0, flag_z_o});
    endtask : expect_out

    task automatic expect_store(input logic [15:0] data);
        expect_out(1'h1, data, 1'h0, 1'h0, 1'h0, 1'h0);
    endtask : expect_store

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        chk("res_valid_o", 16'h0000, {15'h0, res_valid_o});
        chk("idx_pend_o", 16'h0000, {15'h0, idx_pend_o});
        chk("res_data_o", bmu_pkg::RST_DATA, res_data_o);
        @(posedge mclk_i);
        arst_n_i <= 1'h1;
        @(posedge mclk_i);
        $display("test reset done");
    endtask : test_reset

    task automatic test_carry_logic();
        logic sb;
        logic c;
        logic r;
        for (int k = 0; k < 6; k++) begin
            for (int v = 0; v < 4; v++) begin
                c  = v[1];
                sb = v[0] ^ (k > 2);
                r  = (k % 3 == 0) ? (sb & c) : (k % 3 == 1) ? (sb | c) : (sb ^ c);
                drive(bmu_pkg::bmu_op_t'(k), 4'h9, v[0] ? 16'h0200 : 16'hfdff, {c, ~c, 2'h3});
                expect_out(1'h0, 16'h0, 1'h1, r, 1'h0, 1'h0);
            end
        end
        $display("test carry logic done");
    endtask : test_carry_logic

    task automatic test_bit_writes();
        logic [15:0] m;
        logic [15:0] val;
        for (int i = 0; i < 6; i++) begin
            m   = 16'h0001 << ((i % 3) * 7 + (i % 3) / 2);
            val = (i < 3) ? 16'ha5a5 : 16'h5a5a;
            drive(bmu_pkg::bit_force_one, 4'(((i % 3) * 7 + (i % 3) / 2)), val, 4'hf);
            expect_out(1'h1, val | m, 1'h0, 1'h0, 1'h0, 1'h0);
            drive(bmu_pkg::bit_force_zero, 4'(((i % 3) * 7 + (i % 3) / 2)), val, 4'hf);
            expect_out(1'h1, val & ~m, 1'h0, 1'h0, 1'h0, 1'h0);
            drive(bmu_pkg::bit_complement, 4'(((i % 3) * 7 + (i % 3) / 2)), val, 4'h0);
            expect_out(1'h1, val ^ m, 1'h0, 1'h0, 1'h0, 1'h0);
        end
        $display("test bit writes done");
    endtask : test_bit_writes

    task automatic test_probes();
        logic [15:0] val;
        logic        b;
        for (int i = 0; i < 4; i++) begin
            b   = i[0];
            val = b ? 16'h4c31 : 16'hbbce & ~(16'h0001 << (i[1] ? 14 : 2));
            val = b ? val | (16'h0001 << (i[1] ? 14 : 2)) : val;
            drive(bmu_pkg::bit_probe, i[1] ? 4'he : 4'h2, val, {~b, ~b, 2'h0});
            expect_out(1'h0, 16'h0, 1'h1, b, 1'h1, b);
            drive(bmu_pkg::bit_probe_inverted, i[1] ? 4'he : 4'h2, val, {b, b, 2'h0});
            expect_out(1'h0, 16'h0, 1'h1, ~b, 1'h1, ~b);
            drive(bmu_pkg::bit_probe_then_zero, i[1] ? 4'he : 4'h2, val, {~b, ~b, 2'h0});
            expect_out(1'h1, val & ~(16'h0001 << (i[1] ? 14 : 2)), 1'h1, b, 1'h1, b);
            drive(bmu_pkg::bit_probe_then_one, i[1] ? 4'he : 4'h2, val, {~b, ~b, 2'h0});
            expect_out(1'h1, val | (16'h0001 << (i[1] ? 14 : 2)), 1'h1, b, 1'h1, b);
        end
        $display("test probes done");
    endtask : test_probes

    task automatic test_index();
        drive(bmu_pkg::bit_index_prefix, 4'h3, 16'h00fb, 4'h0);
        expect_out(1'h0, 16'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        chk("idx_pend_o", 16'h0001, {15'h0, idx_pend_o});
        drive(bmu_pkg::bit_force_one, 4'h3, 16'h0000, 4'h0);
        expect_store(16'h0800);
        chk("idx_pend_o", 16'h0000, {15'h0, idx_pend_o});
        drive(bmu_pkg::bit_index_prefix, 4'h0, 16'h0002, 4'h0);
        drive(bmu_pkg::bit_index_prefix, 4'h0, 16'h0005, 4'h0);
        drive(bmu_pkg::bit_probe, 4'h0, 16'h0020, 4'h0);
        expect_out(1'h0, 16'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        drive(bmu_pkg::bit_force_zero, 4'h3, 16'hffff, 4'h0);
        expect_store(16'hfff7);
        // Prefix followed by a bit operation in the very next cycle
        @(posedge mclk_i);
        op_valid_i <= 1'h1;
        op_i       <= bmu_pkg::bit_index_prefix;
        operand_i  <= 16'h000c;
        @(posedge mclk_i);
        op_i       <= bmu_pkg::bit_force_one;
        bit_sel_i  <= 4'h1;
        operand_i  <= 16'h0000;
        @(posedge mclk_i);
        op_valid_i <= 1'h0;
        #1;
        expect_store(16'h1000);
        chk("idx_pend_o", 16'h0000, {15'h0, idx_pend_o});
        drive(bmu_pkg::bit_index_prefix, 4'h0, 16'h0007, 4'h0);
        @(posedge mclk_i);
        arst_n_i <= 1'h0;
        #1;
        chk("idx_pend_o", 16'h0000, {15'h0, idx_pend_o});
        test_reset();
        drive(bmu_pkg::bit_force_one, 4'h1, 16'h0000, 4'h0);
        expect_store(16'h0002);
        $display("test index done");
    endtask : test_index

    function automatic logic cond_bit(input int k, input logic c, input logic z,
                                      input logic s, input logic o);
        case (k)
            0:  return c;
            1:  return ~c;
            2:  return z;
            3:  return ~z;
            4:  return c & ~z;
            5:  return ~(c & ~z);
            6:  return ~s;
            7:  return s;
            8:  return ~(s ^ o);
            9:  return s ^ o;
            10: return (s ^ o) | z;
            11: return ~((s ^ o) | z);
            12: return o;
            default: return ~o;
        endcase
    endfunction : cond_bit

    task automatic test_cond_store();
        logic [15:0] val;
        logic [15:0] m;
        logic [15:0] e;
        for (int k = 0; k < 14; k++) begin
            for (int f = 0; f < 16; f++) begin
                val = 16'h6c93 ^ {4{f[3:0]}};
                m   = 16'h0001 << ((f + k) % 16);
                e   = cond_bit(k, f[3], f[2], f[1], f[0]) ? (val | m) : (val & ~m);
                drive(bmu_pkg::bmu_op_t'(k + 14), 4'((f + k) % 16), val, f[3:0]);
                if (k < 4) expect_store(e);
                else expect_store(e);
            end
        end
        $display("test conditional stores done");
    endtask : test_cond_store

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        mismatches = 0;
        cmp_count  = 0;
        arst_n_i   = 1'h0;
        op_valid_i = 1'h0;
        op_i       = bmu_pkg::bit_and_carry;
        bit_sel_i  = 4'h0;
        operand_i  = 16'h0000;
        {flag_c_i, flag_z_i, flag_s_i, flag_o_i} = 4'h0;
        repeat (4) @(posedge mclk_i);
        test_reset();
        test_carry_logic();
        test_bit_writes();
        test_probes();
        test_index();
        test_cond_store();
        conclude();
    end

endmodule : bmu_core_bench
